// ---- rtl/sdw_pkg.sv ----
// Package with constants and types for the serial converter write interface.
// Overview of operation
// - Frame held 24 falling edges; load on 24th
// - Early sync rise discards frame, no update
// - Power-up output zero or midscale until write
// - Refresh at 10 kHz, alternating code, code+1
// - Shift data on each falling clock edge
// - Frame: 2 ignored, 2 reserved, 18 code, 2 ignored
// - Coarse 16 bits; 2 bits pick duty 0-75%
package sdw_pkg;

  localparam int FRAME_BITS = 24;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam int CODE_MSB = 21;
  localparam int CODE_LSB = 4;
  localparam int INTERP_MSB = 3;
  localparam int INTERP_LSB = 2;
  localparam logic [15:0] ZERO_CODE = 16'h0000;
  localparam logic [15:0] MID_CODE = 16'h8000;
  localparam int CLK_HZ = 125000000;
  localparam int UPDATE_HZ = 10000;
  localparam int UPDATE_CYCLES = CLK_HZ / UPDATE_HZ;
  localparam int SUB_CYCLES = UPDATE_CYCLES / 4;
  localparam logic [1:0] PHASES = 2'h3;

  typedef enum logic [2:0] {
    SDW_IDLE = 3'b001,
    SDW_SHIFT = 3'b010,
    SDW_DONE = 3'b100
  } sdw_state_t;

endpackage

// ---- rtl/sdw_sync.sv ----
// Two flip-flop synchroniser for one pin input.
`timescale 1ns/1ps
module sdw_sync
  import sdw_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pinIn,
  output logic      pinOut
);

  typedef struct packed {
    logic meta;
    logic stable;
  } sdw_sync_t;

  sdw_sync_t s;
  sdw_sync_t next_s;

  always_comb
  begin
    next_s.meta = pinIn;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign pinOut = s.stable;

endmodule

// ---- rtl/sdw_serial_dac_write_interface.sv ----
// Serial write front end: frame receiver, converter register and interpolator.
`timescale 1ns/1ps
module sdw_serial_dac_write_interface
  import sdw_pkg::*;
#(
  parameter int UPDATE_CNT = UPDATE_CYCLES,
  parameter bit MIDSCALE_START = 1'b0
)
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        frameSyncN,
  input  wire logic        serialClk,
  input  wire logic        serialData,
  output logic [15:0]      dacInput,
  output logic [15:0]      coarseCode,
  output logic [1:0]       interpCode,
  output logic             loadPulse,
  output logic             abortPulse,
  output logic             tickPulse
);

  localparam int SUB_CNT = UPDATE_CNT / 4;

  typedef struct packed {
    sdw_state_t  state;
    logic [23:0] shiftReg;
    logic [4:0]  bitCount;
    logic        syncPrev;
    logic        clkPrev;
    logic        dataHold;
    logic [15:0] coarse;
    logic [1:0]  interp;
    logic [15:0] dacOut;
    logic [31:0] subCount;
    logic [1:0]  phase;
    logic        load;
    logic        abort;
    logic        tick;
  } sdw_core_t;

  sdw_core_t r;
  sdw_core_t next_r;
  logic      syncN;
  logic      syncLow;
  logic      sclk;
  logic      sdata;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // The synchronisers clear to zero on reset. Frame sync idles high, so it is
  // carried inverted through its synchroniser. Otherwise the synchronised copy
  // would read low after reset and look like a falling edge of frame sync,
  // which would start a false frame that then ends in an abort.
  sdw_sync uSyncFs
  (
    .clk    (mclk),
    .rst    (rst),
    .pinIn  (~frameSyncN),
    .pinOut (syncLow)
  );

  assign syncN = ~syncLow;

  // The serial clock idles low, which matches the reset value of its synchroniser.
  sdw_sync uSyncCk
  (
    .clk    (mclk),
    .rst    (rst),
    .pinIn  (serialClk),
    .pinOut (sclk)
  );

  // Data passes the same two stages as the clock, so both keep their alignment.
  sdw_sync uSyncDt
  (
    .clk    (mclk),
    .rst    (rst),
    .pinIn  (serialData),
    .pinOut (sdata)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.syncPrev = syncN;
    next_r.clkPrev = sclk;
    next_r.dataHold = sdata;
    next_r.load = 1'b0;
    next_r.abort = 1'b0;
    next_r.tick = 1'b0;
    // Data is taken one cycle late so it pairs with the synchronised clock edge.
    unique case (r.state)
      SDW_IDLE:
      begin
        if (r.syncPrev && !syncN)
        begin
          next_r.state = SDW_SHIFT;
          next_r.bitCount = 5'h00;
          next_r.shiftReg = 24'h000000;
        end
      end
      SDW_SHIFT:
      begin
        if (syncN)
        begin
          next_r.state = SDW_IDLE;
          next_r.shiftReg = 24'h000000;
          next_r.bitCount = 5'h00;
          next_r.abort = 1'b1;
        end
        else if (r.clkPrev && !sclk)
        begin
          next_r.shiftReg = {r.shiftReg[22:0], r.dataHold};
          next_r.bitCount = r.bitCount + 5'h01;
          if (r.bitCount == FRAME_LAST)
          begin
            // Bits 23:22 and 1:0 are ignored; reserved 21:20 are discarded.
            next_r.coarse = {r.shiftReg[18:3]};
            next_r.interp = {r.shiftReg[2], r.shiftReg[1]};
            next_r.load = 1'b1;
            next_r.state = SDW_DONE;
          end
        end
      end
      SDW_DONE:
      begin
        if (syncN)
        begin
          next_r.state = SDW_IDLE;
        end
      end
      default:
      begin
        next_r.state = SDW_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // Interpolator
    // ----------------------------------------------------------------
    // Four sub-slots make one update period, with code+1 in the first N slots.
    // A newly loaded code takes effect at the next slot boundary, so the
    // output never shows a partly updated slot.
    // Code+1 saturates at full scale rather than wrapping back to zero.
    if (r.subCount >= 32'(SUB_CNT - 1))
    begin
      next_r.subCount = 32'h00000000;
      next_r.phase = r.phase + 2'h1;
      if (r.phase == PHASES)
      begin
        next_r.tick = 1'b1;
      end
      if ((r.phase + 2'h1) < r.interp && r.coarse != 16'hFFFF)
      begin
        next_r.dacOut = r.coarse + 16'h0001;
      end
      else
      begin
        next_r.dacOut = r.coarse;
      end
    end
    else
    begin
      next_r.subCount = r.subCount + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
      r.state <= SDW_IDLE;
      r.syncPrev <= 1'b1;
      r.coarse <= MIDSCALE_START ? MID_CODE : ZERO_CODE;
      r.dacOut <= MIDSCALE_START ? MID_CODE : ZERO_CODE;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a field of the state register, so it comes from a flip-flop.
  assign dacInput = r.dacOut;
  assign coarseCode = r.coarse;
  assign interpCode = r.interp;
  assign loadPulse = r.load;
  assign abortPulse = r.abort;
  assign tickPulse = r.tick;

endmodule

// ---- bench/sdw_chk_assertions.sv ----
// Port checker for the serial write front end.
`timescale 1ns/1ps
module sdw_chk #(parameter int UPDATE_CNT = 16)
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        frameSyncN,
  input wire logic        serialClk,
  input wire logic [15:0] coarseCode,
  input wire logic [1:0]  interpCode,
  input wire logic        loadPulse,
  input wire logic        abortPulse,
  input wire logic        tickPulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_load_gap: assert property (loadPulse |=> !loadPulse [*8]) else $error("load");
  a_abort_gap: assert property (abortPulse |=> !abortPulse [*8]) else $error("abort");
  a_pulse_excl: assert property (!(loadPulse && abortPulse)) else $error("both");
  a_code_hold: assert property ($changed({coarseCode, interpCode}) |-> loadPulse) else $error("code");
  a_abort_cause: assert property (abortPulse |-> $past(frameSyncN, 2)) else $error("cause");
  a_load_edge: assert property (loadPulse |-> !$past(serialClk, 2)) else $error("edge");
  a_tick_period: assert property (tickPulse |-> ##UPDATE_CNT tickPulse) else $error("tick");
  a_tick_width: assert property (tickPulse |=> !tickPulse) else $error("width");
  cover property (loadPulse);
  cover property (abortPulse);
  cover property (tickPulse && interpCode == 2'h3);
endmodule
bind sdw_serial_dac_write_interface sdw_chk #(.UPDATE_CNT(UPDATE_CNT)) sdw_chk_i(.*);

// ---- bench/sdw_host.sv ----
// Host serial master model driving frame sync, clock and data.
`timescale 1ns/1ps
module sdw_host
(
  output logic frameSyncN,
  output logic serialClk,
  output logic serialData
);
  initial
  begin
    frameSyncN = 1'b1;
    serialClk = 1'b0;
    serialData = 1'b0;
  end
  task automatic send(input logic [23:0] w, input int n);
    frameSyncN = 1'b0;
    #40;
    for (int i = 0; i < n; i++)
    begin
      serialClk = 1'b1;
      serialData = w[23 - (i % 24)];
      #40 serialClk = 1'b0;
      #40;
      if (i % 8 == 7) #120;
    end
    frameSyncN = 1'b1;
    serialData = ~serialData;
    #400;
  endtask
endmodule

// ---- bench/test_serial_dac_write_interface.sv ----
// Self-checking bench for the serial write front end.
`timescale 1ns/1ps
module test_serial_dac_write_interface;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        frameSyncN, serialClk, serialData, loadPulse, abortPulse, tickPulse;
  logic [15:0] dacInput, coarseCode;
  logic [1:0]  interpCode;
  int          failures = 0;
  int          samples_checked = 0;
  int          aborts = 0;
  int          loads = 0;
  always #4 mclk = ~mclk;
  always @(posedge mclk) aborts += (abortPulse === 1'b1);
  always @(posedge mclk) loads += (loadPulse === 1'b1);
  sdw_host sdw_host_i(.frameSyncN(frameSyncN), .serialClk(serialClk), .serialData(serialData));
  sdw_serial_dac_write_interface #(.UPDATE_CNT(16)) sdw_serial_dac_write_interface_i(
    .mclk(mclk), .rst(rst), .frameSyncN(frameSyncN), .serialClk(serialClk),
    .serialData(serialData), .dacInput(dacInput), .coarseCode(coarseCode),
    .interpCode(interpCode), .loadPulse(loadPulse), .abortPulse(abortPulse),
    .tickPulse(tickPulse));
  task chk(input string n, input logic [17:0] e, input logic [17:0] s);
    samples_checked++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task end_of_test;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task load(input logic [23:0] w, input int n);
    int l;
    l = loads;
    sdw_host_i.send(w, n);
    chk("code", {w[19:4], w[3:2]}, {coarseCode, interpCode});
    chk("loads", 18'(l + 1), 18'(loads));
  endtask
  task t_interp(input logic [1:0] k);
    int hi;
    load({4'h0, 16'h1234, k, 2'h0}, 24);
    hi = 0;
    @(posedge tickPulse);
    repeat (16)
    begin
      @(posedge mclk);
      #1;
      hi += (dacInput === 16'h1235);
    end
    chk("duty", 18'(4 * k), 18'(hi));
  endtask
  task t_abort;
    int a;
    a = aborts;
    sdw_host_i.send(24'hFFFFFF, 23);
    chk("abort", 18'(a + 1), 18'(aborts));
    chk("kept", {16'h1234, 2'h3}, {coarseCode, interpCode});
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    #1 rst = 1'b0;
    chk("reset", 18'h0, {dacInput, interpCode});
    chk("resetcode", 18'h0, {coarseCode, 2'h0});
    for (int k = 0; k < 4; k++) t_interp(k[1:0]);
    t_abort;
    load(24'hC3A5F1, 30);
    end_of_test;
  end
  initial
  begin
    #200000;
    failures++;
    end_of_test;
  end
endmodule
